//--- include/tss_pkg.sv
package tss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SETTLE = 8'h00;
  localparam logic [7:0] OFS_TRIG_SRC = 8'h04;
  localparam logic [7:0] OFS_QUERY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ERRORS = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;

  // Limits and defaults
  localparam logic [15:0] SETTLE_MAX = 16'd65000;
  localparam logic [15:0] SETTLE_RST = 16'h0000;
  localparam logic [2:0] TRIG_SRC_RST = 3'h7;
  localparam logic [6:0] STEP_MAX = 7'd100;
  localparam logic [6:0] STEP_RST = 7'h00;
  localparam logic [7:0] SETUP_IDX_MAX = 8'd100;
  localparam logic [7:0] CARD_UNIT_MAX = 8'd4;
  localparam logic [31:0] CARD_NONE = 32'h4E4F4E45;

  // Timing: one millisecond at the 25 ns clock
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 25;
  localparam int MS_CYCLES = MS_NS / CLK_NS;

  // Trigger source groups, the low code bit is a don't care
  localparam logic [1:0] SRC_TALK = 2'h0;
  localparam logic [1:0] SRC_GET = 2'h1;
  localparam logic [1:0] SRC_XCHR = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Query selectors
  localparam logic [2:0] Q_MACHINE = 3'h0;
  localparam logic [2:0] Q_ERRORS = 3'h1;
  localparam logic [2:0] Q_SETUP = 3'h2;
  localparam logic [2:0] Q_POINTER = 3'h3;
  localparam logic [2:0] Q_SLAVES = 3'h4;
  localparam logic [2:0] Q_CARDS = 3'h5;
  localparam logic [2:0] Q_SETTLE = 3'h6;
  localparam logic [2:0] Q_DIGIN = 3'h7;

  // Error word bit positions
  localparam int ERR_W = 9;
  localparam int E_BAD_CMD = 0;
  localparam int E_BAD_OPT = 1;
  localparam int E_NOT_REMOTE = 2;
  localparam int E_SELFTEST = 3;
  localparam int E_OVERRUN = 4;
  localparam int E_PREMATURE = 5;
  localparam int E_LOOP = 6;
  localparam int E_INIT = 7;
  localparam int E_SETUP_CKSUM = 8;

  // Command register bits
  localparam int CMD_RESTORE = 0;
  localparam int CMD_CLEAR = 1;

  typedef enum logic [1:0] {
    ST_SETTLED,
    ST_RELAY,
    ST_USER
  } tss_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tss_apb_req_s;
endpackage : tss_pkg

//--- rtl/tss_core.sv
module tss_core #(
  parameter int MS_TICK_CYCLES = tss_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire tss_pkg::tss_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus front-end events, one-cycle pulses on ref_clk, and the remote_state level
  input wire logic talk_byte_req,
  input wire logic get_pulse,
  input wire logic x_char,
  input wire logic remote_state,
  input wire logic dev_clear,
  input wire logic bad_command_error,
  input wire logic bad_option_error,
  // Fault reports from system logic
  input wire logic selftest_fail,
  input wire logic setup_cksum_fail,
  input wire logic loop_fault,
  input wire logic init_cksum_fail,
  // External trigger pin, asynchronous
  input wire logic ext_trig_pin,
  // System data for queries
  input wire logic [15:0] relay_settle_ms,
  input wire logic [2:0] slave_count,
  input wire logic [7:0] digital_in,
  input wire logic [31:0] item_data,
  // Relay and status outputs
  output logic [6:0] step_ptr,
  output logic load_setup,
  output logic relay_ready,
  output logic matrix_settled,
  output logic error_flag,
  output logic [7:0] query_index,
  output logic [31:0] reply_word,
  output logic reply_valid
);
  tss_pkg::tss_state_e state_q, state_d;
  logic [15:0] settle_q;
  logic [2:0] trig_src_q;
  logic [2:0] qsel_q;
  logic [7:0] qidx_q;
  logic q_armed_q;
  logic [tss_pkg::ERR_W-1:0] err_q;
  logic [6:0] step_q;
  logic [15:0] cyc_q;
  logic [16:0] ms_q;
  logic [2:0] ext_sync_q;
  logic ext_level_q;

  // APB decode; zero wait states so the access phase completes at once
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic wr = acc && apb_req.pwrite;
  wire logic rd = acc && !apb_req.pwrite;
  wire logic hit_settle = apb_req.paddr == tss_pkg::OFS_SETTLE;
  wire logic hit_src = apb_req.paddr == tss_pkg::OFS_TRIG_SRC;
  wire logic hit_query = apb_req.paddr == tss_pkg::OFS_QUERY;
  wire logic hit_status = apb_req.paddr == tss_pkg::OFS_STATUS;
  wire logic hit_err = apb_req.paddr == tss_pkg::OFS_ERRORS;
  wire logic hit_cmd = apb_req.paddr == tss_pkg::OFS_COMMAND;
  wire logic mapped = hit_settle | hit_src | hit_query | hit_status | hit_err | hit_cmd;

  // Write effects
  wire logic settle_wr = wr && hit_settle;
  wire logic settle_ok = apb_req.pwdata[15:0] <= tss_pkg::SETTLE_MAX && apb_req.pwdata[31:16] == 16'h0000;
  wire logic src_wr = wr && hit_src;
  wire logic query_wr = wr && hit_query;
  wire logic [2:0] qsel_w = apb_req.pwdata[2:0];
  wire logic [7:0] qidx_w = apb_req.pwdata[15:8];
  wire logic query_ok = !((qsel_w == tss_pkg::Q_SETUP && qidx_w > tss_pkg::SETUP_IDX_MAX)
                      || (qsel_w == tss_pkg::Q_CARDS && qidx_w > tss_pkg::CARD_UNIT_MAX));
  wire logic restore = wr && hit_cmd && apb_req.pwdata[tss_pkg::CMD_RESTORE];
  wire logic defaults = restore || dev_clear || (wr && hit_cmd && apb_req.pwdata[tss_pkg::CMD_CLEAR]);
  wire logic err_rd = rd && hit_err;

  // External pin: accept a level only once stages two and three agree
  wire logic ext_agree = ext_sync_q[1] == ext_sync_q[2];
  wire logic ext_fall = ext_agree && ext_level_q && !ext_sync_q[2];

  // Trigger selection by source group
  wire logic [1:0] grp = trig_src_q[2:1];
  wire logic trig_talk = grp == tss_pkg::SRC_TALK && talk_byte_req;
  wire logic trig_get = grp == tss_pkg::SRC_GET && get_pulse;
  wire logic x_ok = x_char && remote_state;
  wire logic trig_x = (grp == tss_pkg::SRC_XCHR && x_ok)
                   || (src_wr && apb_req.pwdata[2:1] == tss_pkg::SRC_XCHR);
  wire logic trig_ext = grp == tss_pkg::SRC_EXT && ext_fall;
  wire logic trig_evt = (trig_talk || trig_get || trig_x || trig_ext) && !defaults;
  wire logic trig_overrun = trig_evt && state_q == tss_pkg::ST_RELAY;
  wire logic trig_premature = trig_evt && state_q == tss_pkg::ST_USER;
  wire logic trig_take = trig_evt && !trig_overrun;
  wire logic [6:0] step_next = (step_q == tss_pkg::STEP_MAX) ? step_q : step_q + 7'd1;

  // Millisecond tick and phase end detection
  wire logic ms_tick = cyc_q == 16'(MS_TICK_CYCLES - 1);
  wire logic relay_done = ms_q >= {1'b0, relay_settle_ms};
  wire logic user_done = ms_q >= {1'b0, settle_q};

  // Error sources, gathered per bit
  wire logic [tss_pkg::ERR_W-1:0] err_set = {
    setup_cksum_fail, init_cksum_fail, loop_fault, trig_premature, trig_overrun,
    selftest_fail, x_char && !remote_state,
    bad_option_error || (settle_wr && !settle_ok) || (query_wr && !query_ok),
    bad_command_error};

  // Query answer, sampled at the moment of talk
  wire logic reply_now = talk_byte_req && q_armed_q;
  wire logic [31:0] card_word = (item_data == 32'h0000_0000) ? tss_pkg::CARD_NONE : item_data;
  logic [31:0] item_mux;
  always_comb
  begin
    unique case (qsel_q)
      tss_pkg::Q_MACHINE: item_mux = {13'h0000, trig_src_q, settle_q};
      tss_pkg::Q_ERRORS: item_mux = {23'h000000, err_q};
      tss_pkg::Q_SETUP: item_mux = item_data;
      tss_pkg::Q_POINTER: item_mux = {25'h0000000, step_q};
      tss_pkg::Q_SLAVES: item_mux = {29'h00000000, slave_count};
      tss_pkg::Q_CARDS: item_mux = card_word;
      tss_pkg::Q_SETTLE: item_mux = {16'h0000, relay_settle_ms};
      tss_pkg::Q_DIGIN: item_mux = {24'h000000, digital_in};
    endcase
  end

  // Read data mux
  wire logic [31:0] rd_mux =
      hit_settle ? {16'h0000, settle_q} :
      hit_src ? {29'h00000000, trig_src_q} :
      hit_query ? {16'h0000, qidx_q, 4'h0, q_armed_q, qsel_q} :
      hit_status ? {20'h00000, error_flag, matrix_settled, relay_ready, step_q, 2'h0} :
      hit_err ? {23'h000000, err_q} : 32'h0000_0000;

  // Settling sequence
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      tss_pkg::ST_SETTLED: if (trig_take) state_d = tss_pkg::ST_RELAY;
      tss_pkg::ST_RELAY: if (relay_done) state_d = tss_pkg::ST_USER;
      tss_pkg::ST_USER:
      begin
        if (trig_take) state_d = tss_pkg::ST_RELAY;
        else if (user_done) state_d = tss_pkg::ST_SETTLED;
      end
    endcase
    if (defaults) state_d = tss_pkg::ST_SETTLED;
  end

  // Phase timer restarts whenever a phase starts
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      cyc_q <= 16'h0000;
      ms_q <= 17'h00000;
    end else if (state_d != state_q) begin
      cyc_q <= 16'h0000;
      ms_q <= 17'h00000;
    end else if (ms_tick) begin
      cyc_q <= 16'h0000;
      ms_q <= ms_q + 17'h00001;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  // State and settle indicators
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      state_q <= tss_pkg::ST_SETTLED;
      relay_ready <= 1'b1;
      matrix_settled <= 1'b1;
    end else begin
      state_q <= state_d;
      relay_ready <= state_d != tss_pkg::ST_RELAY;
      matrix_settled <= state_d == tss_pkg::ST_SETTLED;
    end
  end

  // Programmed settings; defaults restored on clear or restore
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      settle_q <= tss_pkg::SETTLE_RST;
      trig_src_q <= tss_pkg::TRIG_SRC_RST;
    end else if (defaults) begin
      settle_q <= tss_pkg::SETTLE_RST;
      trig_src_q <= tss_pkg::TRIG_SRC_RST;
    end else begin
      if (settle_wr && settle_ok) settle_q <= apb_req.pwdata[15:0];
      if (src_wr) trig_src_q <= apb_req.pwdata[2:0];
    end
  end

  // Step pointer and setup load strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      step_q <= tss_pkg::STEP_RST;
      load_setup <= 1'b0;
    end else begin
      load_setup <= trig_take || defaults;
      if (defaults) step_q <= tss_pkg::STEP_RST;
      else if (trig_take) step_q <= step_next;
    end
  end
  assign step_ptr = step_q;

  // Error bits: a new event wins over a clearing read in the same cycle
  for (genvar i = 0; i < tss_pkg::ERR_W; i++) begin : g_err
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n) err_q[i] <= 1'b0;
      else if (err_set[i]) err_q[i] <= 1'b1;
      else if (err_rd || (reply_now && qsel_q == tss_pkg::Q_ERRORS)) err_q[i] <= 1'b0;
    end
  end

  // Serial poll error flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) error_flag <= 1'b0;
    else error_flag <= |err_q;
  end

  // Query arming and one-shot reply
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      qsel_q <= tss_pkg::Q_MACHINE;
      qidx_q <= 8'h00;
      q_armed_q <= 1'b0;
      reply_word <= 32'h0000_0000;
      reply_valid <= 1'b0;
    end else begin
      reply_valid <= reply_now;
      if (reply_now) reply_word <= item_mux;
      if (query_wr && query_ok) begin
        qsel_q <= qsel_w;
        qidx_q <= qidx_w;
        q_armed_q <= 1'b1;
      end else if (reply_now) begin
        q_armed_q <= 1'b0;
      end
    end
  end
  assign query_index = qidx_q;

  // External pin synchroniser and filtered level
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      ext_sync_q <= 3'h7;
      ext_level_q <= 1'b1;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_trig_pin};
      if (ext_agree) ext_level_q <= ext_sync_q[2];
    end
  end

  // APB answer registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= apb_req.psel && !apb_req.penable;
      pslverr <= apb_req.psel && !apb_req.penable && !mapped;
      prdata <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_step_saturate: assert property (trig_take && step_q == tss_pkg::STEP_MAX |=> step_q == tss_pkg::STEP_MAX)
    else $error("step pointer passed 100");
  chk_step_advance: assert property (trig_take && !defaults && step_q < tss_pkg::STEP_MAX
      |=> step_q == $past(step_q) + 7'd1 && load_setup)
    else $error("trigger did not advance pointer");
  chk_overrun_drop: assert property (trig_evt && state_q == tss_pkg::ST_RELAY
      |=> err_q[tss_pkg::E_OVERRUN] && $stable(step_q))
    else $error("overrun trigger not dropped");
  chk_premature_flag: assert property (trig_evt && state_q == tss_pkg::ST_USER && !defaults
      |=> err_q[tss_pkg::E_PREMATURE] && !relay_ready)
    else $error("premature trigger not flagged");
  chk_defaults_set: assert property (defaults
      |=> settle_q == tss_pkg::SETTLE_RST && trig_src_q == tss_pkg::TRIG_SRC_RST)
    else $error("defaults not restored");
  chk_settle_limit: assert property (settle_q <= tss_pkg::SETTLE_MAX)
    else $error("settle delay above limit");
  chk_err_clear: assert property (err_rd && err_set == '0 |=> err_q == '0 ##1 !error_flag)
    else $error("error read did not clear");
  chk_flag_follow: assert property (err_q != '0 |=> error_flag)
    else $error("error flag missing");
  chk_reply_once: assert property (reply_valid |=> !reply_valid)
    else $error("reply repeated");
  chk_settled_drop: assert property (trig_take && !defaults |=> !matrix_settled && !relay_ready)
    else $error("settled not dropped on trigger");
  chk_not_remote: assert property (x_char && !remote_state |=> err_q[tss_pkg::E_NOT_REMOTE])
    else $error("not-remote error missing");
  chk_x_mode_trig: assert property (src_wr && apb_req.pwdata[2:1] == tss_pkg::SRC_XCHR
      && state_q == tss_pkg::ST_SETTLED |=> load_setup)
    else $error("X mode switch did not trigger");
endmodule : tss_core

//--- test/tss_host_model.sv
module tss_host_model (
  // Clock
  input wire logic ref_clk,
  // Bus events and trigger pin
  output logic talk_byte_req,
  output logic get_pulse,
  output logic x_char,
  output logic dev_clear,
  output logic ext_trig_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels; the pin rests high since its falling edge fires
  initial
  begin
    {talk_byte_req, get_pulse, x_char, dev_clear} = 4'h0;
    ext_trig_pin = 1'b1;
  end

  // One-cycle bus event, or a pin held low long enough to pass the sync
  task fire(input int k);
    @(posedge ref_clk);
    case (k)
      0: talk_byte_req <= 1'b1;
      1: get_pulse <= 1'b1;
      2: x_char <= 1'b1;
      3: ext_trig_pin <= 1'b0;
      default: dev_clear <= 1'b1;
    endcase
    @(posedge ref_clk);
    {talk_byte_req, get_pulse, x_char, dev_clear} <= 4'h0;
    if (k == 3)
      repeat (3) @(posedge ref_clk);
    ext_trig_pin <= 1'b1;
  endtask : fire
endmodule : tss_host_model

//--- test/test_trigger_settle_status.sv
module test_trigger_settle_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int RMS = 2;
  logic ref_clk;
  logic rst_n;
  tss_pkg::tss_apb_req_s req;
  logic pready, pslverr, er, remote_state, load_setup, relay_ready, matrix_settled, error_flag, reply_valid;
  logic talk, get, xc, dclr, ext;
  logic [5:0] flt;
  logic [15:0] rsm;
  logic [2:0] slv;
  logic [7:0] din, query_index;
  logic [6:0] step_ptr;
  logic [31:0] prdata, reply_word, item_data, rnd, rd;
  int fail_count, check_count, cyc, step, errs, src, settle, n;

  tss_core #(.MS_TICK_CYCLES(TICK)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .talk_byte_req(talk), .get_pulse(get), .x_char(xc), .remote_state(remote_state), .dev_clear(dclr),
    .bad_command_error(flt[0]), .bad_option_error(flt[1]), .selftest_fail(flt[2]), .setup_cksum_fail(flt[3]),
    .loop_fault(flt[4]), .init_cksum_fail(flt[5]), .ext_trig_pin(ext), .relay_settle_ms(rsm),
    .slave_count(slv), .digital_in(din), .item_data(item_data), .step_ptr(step_ptr), .load_setup(load_setup),
    .relay_ready(relay_ready), .matrix_settled(matrix_settled), .error_flag(error_flag),
    .query_index(query_index), .reply_word(reply_word), .reply_valid(reply_valid)
  );
  tss_host_model p (.ref_clk(ref_clk), .talk_byte_req(talk), .get_pulse(get), .x_char(xc), .dev_clear(dclr),
    .ext_trig_pin(ext));

  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("CHECK FAILED run_length expected end seen hang");
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin

  // APB master; no wait count assumed, the hang guard ends a stall
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk_pin(nm, e, rd);
  endtask : rdchk

  // Fire an event (k < 0: none) and check whether the step advances
  task automatic trig(input int k, input bit exp);
    bit seen;
    seen = 0;
    fork
      if (k >= 0) p.fire(k);
    join_none
    repeat (12)
    begin
      @(posedge ref_clk);
      if (load_setup === 1'b1)
        seen = 1;
    end
    if (exp)
      step = (step < 100) ? step + 1 : 100;
    chk_pin("load_setup", exp, seen);
    chk_pin("step_ptr", step, step_ptr);
    while (matrix_settled !== 1'b1)
      @(posedge ref_clk);
  endtask : trig

  // Arm a query, ask for the first byte, catch the single reply
  task automatic qry(input int sel, input int idx, input logic [31:0] e);
    bit seen;
    logic [31:0] w;
    seen = 0;
    w = 32'h0;
    apb(1'b1, tss_pkg::OFS_QUERY, (idx << 8) | sel);
    fork
      p.fire(0);
    join_none
    repeat (8)
    begin
      @(posedge ref_clk);
      if (reply_valid === 1'b1 && !seen)
      begin
        seen = 1;
        w = reply_word;
      end
    end
    chk_pin("reply_valid", 1, seen);
    chk_pin("reply_word", e, w);
    chk_pin("query_index", idx, query_index);
  endtask : qry

  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Main sequence, model kept in step, src, settle and errs
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    remote_state = 1'b1;
    flt = 6'h00;
    rsm = RMS;
    {slv, din, item_data} = '0;
    rnd = 32'h31C8;
    {fail_count, check_count, cyc, step, errs, settle} = '0;
    src = 7;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(tss_pkg::OFS_STATUS, 32'h600, "status");
    rdchk(tss_pkg::OFS_SETTLE, 0, "settle");
    rdchk(tss_pkg::OFS_TRIG_SRC, 7, "trig_src");
    rdchk(8'h3C, 0, "unmapped");
    chk_pin("pslverr", 1, er);
    $display("test reset done");
    apb(1'b1, tss_pkg::OFS_SETTLE, 65000);
    rdchk(tss_pkg::OFS_SETTLE, 65000, "settle_max");
    apb(1'b1, tss_pkg::OFS_SETTLE, 65001);
    errs |= 2;
    rdchk(tss_pkg::OFS_SETTLE, 65000, "settle_over");
    rnd = lfsr(rnd);
    apb(1'b1, tss_pkg::OFS_SETTLE, rnd[15:0] % 65001);
    rdchk(tss_pkg::OFS_SETTLE, rnd[15:0] % 65001, "settle_rand");
    apb(1'b1, tss_pkg::OFS_SETTLE, 0);
    $display("test settle done");
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, tss_pkg::OFS_TRIG_SRC, c);
      if (c / 2 == 2)
        trig(-1, 1);
      trig((c / 2 + 1) % 4, 0);
      trig(c / 2, 1);
    end
    $display("test sources done");
    src = 2;
    settle = 3;
    apb(1'b1, tss_pkg::OFS_TRIG_SRC, src);
    apb(1'b1, tss_pkg::OFS_SETTLE, settle);
    fork
      p.fire(1);
    join_none
    while (relay_ready !== 1'b0)
      @(posedge ref_clk);
    n = 0;
    while (relay_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_pin("relay_phase", 1, n >= RMS * TICK && n <= RMS * TICK + 2);
    n = 0;
    while (matrix_settled !== 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_pin("user_phase", 1, n >= settle * TICK && n <= settle * TICK + 2);
    fork
      p.fire(1);
    join_none
    while (relay_ready !== 1'b0)
      @(posedge ref_clk);
    p.fire(1);
    while (relay_ready !== 1'b1)
      @(posedge ref_clk);
    p.fire(1);
    step += 3;
    errs |= 32'h30;
    repeat (2) @(posedge ref_clk);
    while (matrix_settled !== 1'b1)
      @(posedge ref_clk);
    chk_pin("step_ptr", step, step_ptr);
    $display("test timing done");
    remote_state <= 1'b0;
    p.fire(2);
    flt <= 6'h3F;
    remote_state <= 1'b1;
    @(posedge ref_clk);
    flt <= 6'h00;
    errs |= 32'h1CD;
    repeat (3) @(posedge ref_clk);
    chk_pin("error_flag", 1, error_flag);
    rdchk(tss_pkg::OFS_ERRORS, errs, "errors");
    errs = 0;
    rdchk(tss_pkg::OFS_ERRORS, 0, "errors_cleared");
    // Random fault pattern, each report must land on its own bit
    rnd = lfsr(rnd);
    flt <= rnd[5:0];
    @(posedge ref_clk);
    flt <= 6'h00;
    rdchk(tss_pkg::OFS_ERRORS, {rnd[3], rnd[5], rnd[4], 2'b00, rnd[2], 1'b0, rnd[1], rnd[0]}, "errors_rand");
    repeat (2) @(posedge ref_clk);
    chk_pin("error_flag", 0, error_flag);
    $display("test errors done");
    rnd = lfsr(rnd);
    item_data <= rnd;
    slv <= rnd[2:0];
    din <= rnd[15:8];
    qry(0, 0, (src << 16) | settle);
    qry(3, 0, step);
    qry(4, 0, rnd[2:0]);
    qry(7, 0, rnd[15:8]);
    qry(6, 0, RMS);
    qry(2, 100, rnd);
    qry(5, 3, rnd);
    item_data <= 32'h0;
    qry(5, 0, tss_pkg::CARD_NONE);
    n = 0;
    fork
      p.fire(0);
    join_none
    repeat (8)
    begin
      @(posedge ref_clk);
      if (reply_valid === 1'b1)
        n++;
    end
    chk_pin("repeat_reply", 0, n);
    apb(1'b1, tss_pkg::OFS_QUERY, (101 << 8) | 2);
    qry(1, 0, 2);
    $display("test queries done");
    apb(1'b1, tss_pkg::OFS_SETTLE, 0);
    for (int i = 0; i < 92; i++)
      trig(1, 1);
    $display("test saturate done");
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, tss_pkg::OFS_SETTLE, 5);
      apb(1'b1, tss_pkg::OFS_TRIG_SRC, 2);
      if (k == 0)
        p.fire(4);
      else
        apb(1'b1, tss_pkg::OFS_COMMAND, k);
      repeat (3) @(posedge ref_clk);
      rdchk(tss_pkg::OFS_SETTLE, 0, "settle_clr");
      rdchk(tss_pkg::OFS_TRIG_SRC, 7, "src_clr");
      chk_pin("step_clr", 0, step_ptr);
    end
    $display("test clears done");
    conclude();
  end
endmodule : test_trigger_settle_status
